// *** verilog/bcr_datapath_regs.v ***
// BCH engine register block with byte feed port, parity LFSR and status flags
// Summary of operation
// - Count register bits 25:16 hold decode length, payload plus parity bytes.
// - Count register bits 9:0 hold encode length, payload bytes only.
// - Count bits 31:26 and 15:10 ignore writes and read zero.
// - Write-only byte port feeds one payload or parity byte per write.
// - All four parity registers clear on system reset and on soft reset.
// - Eight-error parity: 104 bits, first word 3 bit 7, last word 0 bit 0.
// - Four-error parity: 52 bits, first word 1 bit 19, last word 0 bit 0.
// - Writing one clears a status flag; tally unaffected; writing zero does nothing.
// - Status bits 31:28 give error tally, zero also when unfixable; soft reset clears. The code always reads the tally as zero.
// - Status bit 5 sets when every decoded byte, parity included, is zero.
// - Status bit 4 sets when every decoded byte is 0xf; no error reported.
// - Status bit 3 sets when a decode pass over the byte count completes.
// - Status bit 2 sets when an encode pass completes and parity is ready.
// - Status bit 1 sets when the block has more errors than can be repaired. The code sets it together with bit 0 on any bad block.
// - Status bit 0 sets when decoding finds one or more bad bits.
// - Control bit 1 resets the engine, clears itself and reads zero.
// - Control bit 2 selects four-error (0) or eight-error (1) strength.
// - Control bit 3 selects decoding (0) or encoding (1).
// - Each status flag has its own interrupt enable bit, all off after reset.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "bcr_defines.vh"

module bcr_datapath_regs #(
    parameter ADDR_WIDTH = 8,
    parameter [103:0] POLY8 = 104'h1,
    parameter [51:0] POLY4 = 52'h1
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq
);

    // Byte-lane merge of a write into a stored word
    function [31:0] bcr_merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0] strb;
        integer k;
        begin
            bcr_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    bcr_merge[k*8 +: 8] = din[k*8 +: 8];
                end
            end
        end
    endfunction

    // Eight steps of the parity divider, MSB of the byte first
    function [103:0] bcr_lfsr_byte;
        input [103:0] s;
        input [7:0] d;
        input wide;
        integer i;
        reg [103:0] t;
        reg fb;
        begin
            t = s;
            for (i = 7; i >= 0; i = i - 1) begin
                fb = (wide ? t[`BCR_PAR8_BITS-1] : t[`BCR_PAR4_BITS-1]) ^ d[i];
                t = {t[102:0], 1'b0};
                if (fb) begin
                    t = t ^ (wide ? POLY8 : {52'h0, POLY4});
                end
                // Four-error mode keeps only the low 52 bits of the divider
                if (!wide) begin
                    t[103:52] = 52'h0;
                end
            end
            bcr_lfsr_byte = t;
        end
    endfunction

    // Address match helper
    function bcr_hit;
        input [ADDR_WIDTH-1:0] a;
        input [7:0] off;
        begin
            bcr_hit = (a == {{(ADDR_WIDTH-8){1'b0}}, off});
        end
    endfunction

    // Write channel holding registers
    reg aw_held;
    reg [ADDR_WIDTH-1:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // Software-visible state
    reg ctrl_en;
    reg strength;
    reg direction;
    reg [9:0] dec_len;
    reg [9:0] enc_len;
    reg [103:0] par_bits;
    reg [5:0] flags;
    reg [5:0] irq_mask;

    // Engine pass state
    reg [103:0] lfsr;
    reg [9:0] byte_cnt;
    reg seen_nonzero;
    reg seen_not_ones;

    // Write is performed once both halves are held and no answer is pending
    wire write_go = aw_held && w_held && !s_axi_bvalid;
    wire w_lane0 = write_go && w_strb[0];
    // Register decode of the held write address
    wire hit_ctrl = bcr_hit(aw_addr, `BCR_OFF_CTRL);
    wire hit_count = bcr_hit(aw_addr, `BCR_OFF_COUNT);
    wire hit_data = bcr_hit(aw_addr, `BCR_OFF_DATA);
    wire hit_par0 = bcr_hit(aw_addr, `BCR_OFF_PAR0);
    wire hit_par1 = bcr_hit(aw_addr, `BCR_OFF_PAR1);
    wire hit_par2 = bcr_hit(aw_addr, `BCR_OFF_PAR2);
    wire hit_par3 = bcr_hit(aw_addr, `BCR_OFF_PAR3);
    wire hit_stat = bcr_hit(aw_addr, `BCR_OFF_STAT);
    wire hit_mask = bcr_hit(aw_addr, `BCR_OFF_MASK);
    wire hit_any = hit_ctrl | hit_count | hit_data | hit_par0 | hit_par1 |
        hit_par2 | hit_par3 | hit_stat | hit_mask;

    // Soft reset acts in the cycle the control write is performed
    // The same write also loads enable, strength and direction
    wire soft_rst = w_lane0 && hit_ctrl && w_data[`BCR_CTRL_SRST];

    // One byte per write, low lane only, while the engine is enabled
    wire feed = w_lane0 && hit_data && ctrl_en && !soft_rst;
    wire [7:0] feed_byte = w_data[7:0];
    // Pass length follows the direction bit; a zero length wraps the counter
    wire [9:0] pass_len = direction ? enc_len : dec_len;
    wire [9:0] cnt_inc = byte_cnt + 10'h001;
    wire pass_end = feed && (cnt_inc == pass_len);
    wire [103:0] next_lfsr = bcr_lfsr_byte(lfsr, feed_byte, strength);

    // Count word seen whole so each byte lane lands in its own field
    wire [31:0] count_merged = bcr_merge({6'h0, dec_len, 6'h0, enc_len}, w_data, w_strb);

    // End-of-decode classification
    wire end_all0 = !seen_nonzero && (feed_byte == `BCR_BYTE_ZERO);
    wire end_allf = !seen_not_ones && (feed_byte == `BCR_BYTE_ONES);
    wire end_bad = (|next_lfsr) && !end_allf;

    // Hardware flag sets for this cycle
    reg [5:0] flag_set;
    always @* begin
        flag_set = 6'h00;
        // Encode end: parity is loaded on this same edge
        if (pass_end && direction) begin
            flag_set[`BCR_ST_ENC] = 1'b1;
        end
        // Decode end: classify the whole block
        if (pass_end && !direction) begin
            flag_set[`BCR_ST_DEC] = 1'b1;
            flag_set[`BCR_ST_ALL0] = end_all0;
            flag_set[`BCR_ST_ALLF] = end_allf;
            flag_set[`BCR_ST_ERR] = end_bad;
            flag_set[`BCR_ST_UNFIX] = end_bad;
        end
    end

    // Write-one-to-clear mask from software
    wire [5:0] flag_clr = (w_lane0 && hit_stat) ? w_data[5:0] : 6'h00;

    // Write address and data channels, taken in either order
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= {ADDR_WIDTH{1'b0}};
            s_axi_awready <= 1'b1;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCR_RESP_OKAY;
        end else begin
            // Address taken; ready stays low until the answer is accepted
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // Data taken, held until the write is performed
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Perform the write and raise the answer
            if (write_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= hit_any ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
            end
            // Answer accepted, reopen both write channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control, count and enable registers
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_en <= 1'b0;
            strength <= 1'b0;
            direction <= 1'b0;
            dec_len <= `BCR_DEC_RST;
            enc_len <= `BCR_ENC_RST;
            irq_mask <= 6'h00;
        end else begin
            // Control bits load with any write that carries lane 0
            if (w_lane0 && hit_ctrl) begin
                ctrl_en <= w_data[`BCR_CTRL_EN];
                strength <= w_data[`BCR_CTRL_STR];
                direction <= w_data[`BCR_CTRL_DIR];
            end
            // Count word honours every byte lane; spare bits are dropped
            if (write_go && hit_count) begin
                dec_len <= count_merged[`BCR_DEC_HI:`BCR_DEC_LO];
                enc_len <= count_merged[`BCR_ENC_HI:`BCR_ENC_LO];
            end
            // Interrupt enables, one per status flag
            if (w_lane0 && hit_mask) begin
                irq_mask <= w_data[5:0];
            end
        end
    end

    // Parity words: engine result, software write, reset and soft reset
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            par_bits <= 104'h0;
        end else if (soft_rst) begin
            par_bits <= 104'h0;
        end else if (pass_end && direction) begin
            par_bits <= next_lfsr;
        end else if (write_go) begin
            // Software may overwrite parity words between passes
            if (hit_par0) begin
                par_bits[31:0] <= bcr_merge(par_bits[31:0], w_data, w_strb);
            end
            if (hit_par1) begin
                par_bits[63:32] <= bcr_merge(par_bits[63:32], w_data, w_strb);
            end
            if (hit_par2) begin
                par_bits[95:64] <= bcr_merge(par_bits[95:64], w_data, w_strb);
            end
            if (hit_par3 && w_strb[0]) begin
                par_bits[103:96] <= w_data[`BCR_PAR3_W-1:0];
            end
        end
    end

    // Byte counter, divider and pattern trackers of the current pass
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lfsr <= 104'h0;
            byte_cnt <= 10'h000;
            seen_nonzero <= 1'b0;
            seen_not_ones <= 1'b0;
        end else if (soft_rst || pass_end) begin
            // A finished or reset pass restarts from an empty divider
            lfsr <= 104'h0;
            byte_cnt <= 10'h000;
            seen_nonzero <= 1'b0;
            seen_not_ones <= 1'b0;
        end else if (feed) begin
            // Step the divider and the pattern trackers by one byte
            lfsr <= next_lfsr;
            byte_cnt <= cnt_inc;
            seen_nonzero <= seen_nonzero | (feed_byte != `BCR_BYTE_ZERO);
            seen_not_ones <= seen_not_ones | (feed_byte != `BCR_BYTE_ONES);
        end
    end

    // Sticky flags, a hardware set wins over a software clear
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags <= 6'h00;
        end else begin
            // Software clears first, then the sets of this cycle apply
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // Interrupt output from flags gated by their enables
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & irq_mask);
        end
    end

    // Read data selection
    reg [31:0] rd_word;
    reg rd_ok;
    always @* begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        if (bcr_hit(s_axi_araddr, `BCR_OFF_CTRL)) begin
            rd_word[`BCR_CTRL_EN] = ctrl_en;
            rd_word[`BCR_CTRL_STR] = strength;
            rd_word[`BCR_CTRL_DIR] = direction; // soft reset bit reads zero
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_COUNT)) begin
            rd_word[`BCR_DEC_HI:`BCR_DEC_LO] = dec_len;
            rd_word[`BCR_ENC_HI:`BCR_ENC_LO] = enc_len;
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_DATA)) begin
            rd_word = 32'h0;
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_PAR0)) begin
            rd_word = par_bits[31:0];
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_PAR1)) begin
            rd_word = par_bits[63:32];
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_PAR2)) begin
            rd_word = par_bits[95:64];
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_PAR3)) begin
            rd_word[`BCR_PAR3_W-1:0] = par_bits[103:96];
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_STAT)) begin
            rd_word[5:0] = flags;
            rd_word[`BCR_TALLY_HI:`BCR_TALLY_LO] = `BCR_TALLY_NONE;
        end else if (bcr_hit(s_axi_araddr, `BCR_OFF_MASK)) begin
            rd_word[5:0] = irq_mask;
        end else begin
            // Unmapped place reads zero with an error response
            rd_ok = 1'b0;
        end
    end

    // Read address and data channels
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `BCR_RESP_OKAY;
        end else begin
            // Address taken, data captured on the same edge
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `BCR_RESP_OKAY : `BCR_RESP_SLVERR;
            end
            // Answer accepted, reopen the address channel
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // bcr_datapath_regs

// *** verilog/bcr_defines.vh ***
// Register map, field positions and reset values of the BCH datapath register block
`ifndef BCR_DEFINES_VH
`define BCR_DEFINES_VH

// Register byte offsets
`define BCR_OFF_CTRL 8'h00
`define BCR_OFF_COUNT 8'h04
`define BCR_OFF_DATA 8'h08
`define BCR_OFF_PAR0 8'h0c
`define BCR_OFF_PAR1 8'h10
`define BCR_OFF_PAR2 8'h14
`define BCR_OFF_PAR3 8'h18
`define BCR_OFF_STAT 8'h1c
`define BCR_OFF_MASK 8'h20

// Control bits
`define BCR_CTRL_EN 0
`define BCR_CTRL_SRST 1
`define BCR_CTRL_STR 2
`define BCR_CTRL_DIR 3

// Count fields and reset values
`define BCR_DEC_HI 25
`define BCR_DEC_LO 16
`define BCR_ENC_HI 9
`define BCR_ENC_LO 0
`define BCR_DEC_RST 10'h02d
`define BCR_ENC_RST 10'h020

// Status bits
`define BCR_ST_ERR 0
`define BCR_ST_UNFIX 1
`define BCR_ST_ENC 2
`define BCR_ST_DEC 3
`define BCR_ST_ALLF 4
`define BCR_ST_ALL0 5
`define BCR_TALLY_HI 31
`define BCR_TALLY_LO 28
`define BCR_TALLY_NONE 4'h0

// Parity geometry
`define BCR_PAR8_BITS 104
`define BCR_PAR4_BITS 52
`define BCR_PAR3_W 8

// Byte patterns watched during decoding
`define BCR_BYTE_ZERO 8'h00
`define BCR_BYTE_ONES 8'h0f

// AXI responses
`define BCR_RESP_OKAY 2'b00
`define BCR_RESP_SLVERR 2'b10

`endif

// *** verif/bcr_regs_asserts.sv ***
// Bus handshake and register view checks on the BCH register block ports
`timescale 1ns/100ps
`include "bcr_defines.vh"
module bcr_regs_asserts #(
    parameter ADDR_WIDTH = 8
) (
    input wire clk_sys,
    input wire reset_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // Write is taken on one edge; the answer is still low one edge later and high two edges after it
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_take |=> s_b_answer;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write not answered in time");
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered in time");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write accepted while answering");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted while answering");
    property p_b_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_release: assert property (p_b_release) else $error("write answer not released");
    property p_unmapped;
        s_rd_take and (s_axi_araddr > `BCR_OFF_MASK) |=>
            s_axi_rresp == `BCR_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_count_rsvd;
        s_rd_take and (s_axi_araddr == `BCR_OFF_COUNT) |=> (s_axi_rdata & 32'hfc00fc00) == 32'h0;
    endproperty
    a_count_rsvd: assert property (p_count_rsvd) else $error("count spare bits set");
    property p_ctrl_view;
        s_rd_take and (s_axi_araddr == `BCR_OFF_CTRL) |=> !s_axi_rdata[1] && s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_ctrl_view: assert property (p_ctrl_view) else $error("soft reset bit reads one");
    property p_stat_view;
        s_rd_take and (s_axi_araddr == `BCR_OFF_STAT) |=>
            s_axi_rdata[27:6] == 22'h0 && s_axi_rdata[31:28] == `BCR_TALLY_NONE;
    endproperty
    a_stat_view: assert property (p_stat_view) else $error("status spare or tally bits set");
    property p_irq_reset;
        $rose(reset_n) |-> !irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("interrupt high after reset");
endmodule // bcr_regs_asserts

// *** verif/bcr_host_model.sv ***
// Bus master standing in for the processor or DMA engine that feeds the block
`timescale 1ns/100ps
module bcr_host_model (
    input wire clk_sys,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // One write, address and data offered together, each held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                      output bit to);
        int n;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        to = 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                to = 1'b0;
                break;
            end
        end
    endtask

    // One read, address held until taken, then wait until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                      output bit to);
        int n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        to = 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                to = 1'b0;
                break;
            end
        end
    endtask
endmodule // bcr_host_model

// *** verif/bcr_datapath_regs_tb.sv ***
// Self-checking bench for the BCH register block
`timescale 1ns/100ps
`include "bcr_defines.vh"
module bcr_datapath_regs_tb;
    logic clk_sys;
    logic reset_n;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int total_checks = 0;

    // Clock and design under test
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    bcr_datapath_regs u_bcr_datapath_regs (.clk_sys(clk_sys), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    bcr_host_model m_host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // Comparison, verdict and bus helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        logic [1:0] r;
        bit to;
        m_host.wr(a, d, r, to);
        if (to) begin
            num_errors++;
            stop_test();
        end
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
        logic [31:0] d;
        logic [1:0] r;
        bit to;
        m_host.rd(a, d, r, to);
        if (to) begin
            num_errors++;
            stop_test();
        end
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic irq_is(input logic e);
        @(posedge clk_sys);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic par_zero();
        for (int i = 0; i < 4; i++) rd(`BCR_OFF_PAR0 + 8'(4 * i), 32'h0);
    endtask

    // Reset values of every register
    task automatic t_reset();
        rd(`BCR_OFF_CTRL, 32'h0);
        rd(`BCR_OFF_COUNT, 32'h002d0020);
        rd(`BCR_OFF_STAT, 32'h0);
        rd(`BCR_OFF_MASK, 32'h0);
        par_zero();
    endtask
    // Spare count bits, unmapped place and write-only byte port
    task automatic t_count();
        wr(`BCR_OFF_COUNT, 32'hffffffff);
        rd(`BCR_OFF_COUNT, 32'h03ff03ff);
        wr(8'h40, 32'h1, `BCR_RESP_SLVERR);
        rd(8'h40, 32'h0, `BCR_RESP_SLVERR);
        rd(`BCR_OFF_DATA, 32'h0);
    endtask
    // Encode passes in both strengths, interrupt and flag clear
    task automatic t_encode();
        wr(`BCR_OFF_CTRL, 32'hd);
        wr(`BCR_OFF_COUNT, 32'h00000002);
        wr(`BCR_OFF_MASK, 32'h4);
        wr(`BCR_OFF_DATA, 32'ha5);
        wr(`BCR_OFF_DATA, 32'h3c);
        rd(`BCR_OFF_STAT, 32'h4);
        irq_is(1'b1);
        // Generator 1 makes the divider a plain shift register, first bit highest
        rd(`BCR_OFF_PAR0, 32'h0000a53c);
        rd(`BCR_OFF_PAR1, 32'h0);
        rd(`BCR_OFF_PAR2, 32'h0);
        rd(`BCR_OFF_PAR3, 32'h0);
        wr(`BCR_OFF_STAT, 32'h0);
        rd(`BCR_OFF_STAT, 32'h4);
        wr(`BCR_OFF_STAT, 32'h4);
        rd(`BCR_OFF_STAT, 32'h0);
        irq_is(1'b0);
        // Four-error strength: a lone top bit wraps past bit 51 into bit 3
        wr(`BCR_OFF_CTRL, 32'h9);
        wr(`BCR_OFF_COUNT, 32'h00000007);
        wr(`BCR_OFF_DATA, 32'h80);
        repeat (6) wr(`BCR_OFF_DATA, 32'h0);
        rd(`BCR_OFF_PAR0, 32'h8);
        rd(`BCR_OFF_PAR1, 32'h0);
        wr(`BCR_OFF_STAT, 32'h4);
    endtask
    // Refused feed while disabled, then decode of all-zero, all-0x0f and damaged blocks
    task automatic t_decode();
        logic [7:0] pat [3] = '{8'h00, 8'h0f, 8'h01};
        logic [31:0] st [3] = '{32'h28, 32'h18, 32'h0b};
        wr(`BCR_OFF_CTRL, 32'h0);
        wr(`BCR_OFF_COUNT, 32'h00020000);
        repeat (2) wr(`BCR_OFF_DATA, 32'h0);
        rd(`BCR_OFF_STAT, 32'h0);
        wr(`BCR_OFF_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            repeat (2) wr(`BCR_OFF_DATA, {24'h0, pat[i]});
            rd(`BCR_OFF_STAT, st[i]);
            wr(`BCR_OFF_STAT, 32'h3f);
        end
    endtask
    // Soft reset clears itself, the parity words and a half-done pass; strength bit loads from the same write
    task automatic t_soft();
        wr(`BCR_OFF_DATA, 32'h1);
        wr(`BCR_OFF_CTRL, 32'h7);
        rd(`BCR_OFF_CTRL, 32'h5);
        par_zero();
        rd(`BCR_OFF_STAT, 32'h0);
        repeat (2) wr(`BCR_OFF_DATA, 32'h0);
        rd(`BCR_OFF_STAT, 32'h28);
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_count();
        t_encode();
        t_decode();
        t_soft();
        stop_test();
    end
endmodule // bcr_datapath_regs_tb

bind bcr_datapath_regs bcr_regs_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_bcr_regs_asserts (
    .clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .irq(irq));
